/* File: rtl/gpct_pkg.sv */
// constants shared by the capture/compare timer
package gpct_pkg;
   localparam int CNT_WIDTH = 32;
   localparam int PRE_WIDTH = 12;
   localparam int NUM_CAPTURE = 2;
   localparam int NUM_COMPARE = 3;
   localparam int NUM_FLAGS = 6;
   localparam int FLAG_CAP_A = 0;
   localparam int FLAG_CAP_B = 1;
   localparam int FLAG_CMP_A = 2;
   localparam int FLAG_CMP_B = 3;
   localparam int FLAG_CMP_C = 4;
   localparam int FLAG_ROLL = 5;
   localparam logic CLK_SRC_REF = 1'h0;
   localparam logic CLK_SRC_EXT = 1'h1;
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 6'h00;
   localparam logic [NUM_COMPARE-1:0] CMP_OUT_RST = 3'h0;
   localparam logic [NUM_CAPTURE-1:0] CAP_PREV_RST = 2'h0;
   localparam logic EXT_PREV_RST = 1'h0;
   localparam logic IRQ_RST = 1'h0;
endpackage

/* File: rtl/gpct_timer.sv */
// capture/compare timer with prescaler, restart and free-run modes
`timescale 1ns/100ps
module gpct_timer import gpct_pkg::*; #(
   parameter int CNT_W = CNT_WIDTH,
   parameter int PRE_W = PRE_WIDTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic timer_enable,
   input wire logic clock_select,
   input wire logic external_counter_clock,
   input wire logic [PRE_W-1:0] prescale_div,
   input wire logic restart_mode,
   input wire logic [CNT_W-1:0] compare_value_a,
   input wire logic [CNT_W-1:0] compare_value_b,
   input wire logic [CNT_W-1:0] compare_value_c,
   input wire logic [NUM_COMPARE-1:0] compare_active_level,
   input wire logic [NUM_COMPARE-1:0] compare_out_enable,
   input wire logic [NUM_COMPARE-1:0] force_compare,
   input wire logic capture_input_a,
   input wire logic capture_input_b,
   input wire logic [1:0] capture_edge_a,
   input wire logic [1:0] capture_edge_b,
   input wire logic [NUM_FLAGS-1:0] flag_clear,
   input wire logic [NUM_FLAGS-1:0] irq_enable,
   output logic [CNT_W-1:0] counter_value,
   output logic [CNT_W-1:0] capture_value_a,
   output logic [CNT_W-1:0] capture_value_b,
   output logic compare_output_a,
   output logic compare_output_b,
   output logic compare_output_c,
   output logic [NUM_FLAGS-1:0] status_flags,
   output logic irq_request
);

   if (CNT_W < 2 || CNT_W > 64) begin : g_bad_cnt
      $error("counter width must be 2 to 64");
   end
   if (PRE_W < 1 || PRE_W > 16) begin : g_bad_pre
      $error("prescaler width must be 1 to 16");
   end

   function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = prev & ~cur;
      case (sel)
         EDGE_RISE: edge_hit = rise;
         EDGE_FALL: edge_hit = fall;
         EDGE_BOTH: edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   logic ext_prev_r;
   logic [PRE_W-1:0] pre_cnt_r;
   logic [PRE_W-1:0] pre_cnt_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [NUM_CAPTURE-1:0] cap_prev_r;
   logic [CNT_W-1:0] cap_val_r [NUM_CAPTURE];
   logic [NUM_COMPARE-1:0] cmp_out_r;
   logic [NUM_FLAGS-1:0] flag_r;
   logic [NUM_FLAGS-1:0] flag_nxt;
   logic irq_r;

   wire [CNT_W-1:0] cmp_val [NUM_COMPARE];
   wire [1:0] cap_sel [NUM_CAPTURE];
   wire [NUM_CAPTURE-1:0] cap_in = {capture_input_b, capture_input_a};
   wire [NUM_CAPTURE-1:0] cap_edge;
   wire [NUM_COMPARE-1:0] cmp_hit;
   wire [NUM_COMPARE-1:0] cmp_evt;

   assign cmp_val[0] = compare_value_a;
   assign cmp_val[1] = compare_value_b;
   assign cmp_val[2] = compare_value_c;
   assign cap_sel[0] = capture_edge_a;
   assign cap_sel[1] = capture_edge_b;

   // pin is taken as synchronous; only its rising edge counts
   wire ext_rise = external_counter_clock & ~ext_prev_r;
   wire src_tick = timer_enable & ((clock_select == CLK_SRC_EXT) ? ext_rise : 1'b1);
   // >= so that lowering the divisor mid-count cannot make the prescaler run all the way round
   wire pre_done = (pre_cnt_r >= prescale_div);
   wire count_adv = src_tick & pre_done;
   wire restart_hit = restart_mode & (cnt_r == cmp_val[0]);
   wire wrap = count_adv & ~restart_hit & (&cnt_r);

   assign pre_cnt_nxt = !src_tick ? pre_cnt_r : (pre_done ? '0 : pre_cnt_r + 1'b1);
   assign cnt_nxt = !count_adv ? cnt_r : (restart_hit ? '0 : cnt_r + 1'b1);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ext_prev_r <= EXT_PREV_RST;
         pre_cnt_r <= '0;
         cnt_r <= '0;
      end else begin
         ext_prev_r <= external_counter_clock;
         pre_cnt_r <= pre_cnt_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   genvar gi;
   for (gi = 0; gi < NUM_COMPARE; gi++) begin : g_cmp
      // match is judged on the value being entered, so each match fires once per pass
      assign cmp_hit[gi] = count_adv & (cnt_nxt == cmp_val[gi]);
      assign cmp_evt[gi] = cmp_hit[gi] | force_compare[gi];
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            cmp_out_r[gi] <= CMP_OUT_RST[gi];
         end else begin
            cmp_out_r[gi] <= (cmp_evt[gi] & compare_out_enable[gi]) ? compare_active_level[gi]
                                                                   : ~compare_active_level[gi];
         end
      end
   end

   for (gi = 0; gi < NUM_CAPTURE; gi++) begin : g_cap
      assign cap_edge[gi] = edge_hit(cap_prev_r[gi], cap_in[gi], cap_sel[gi]);
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            cap_prev_r[gi] <= CAP_PREV_RST[gi];
            cap_val_r[gi] <= '0;
         end else begin
            cap_prev_r[gi] <= cap_in[gi];
            if (cap_edge[gi]) begin
               cap_val_r[gi] <= cnt_r;
            end
         end
      end
   end

   // a new event in the clearing cycle keeps its flag
   assign flag_nxt = (flag_r & ~flag_clear) | {wrap, cmp_evt, cap_edge};

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flag_r <= FLAGS_RST;
         irq_r <= IRQ_RST;
      end else begin
         flag_r <= flag_nxt;
         irq_r <= |(flag_nxt & irq_enable);
      end
   end

   assign counter_value = cnt_r;
   assign capture_value_a = cap_val_r[0];
   assign capture_value_b = cap_val_r[1];
   assign compare_output_a = cmp_out_r[0];
   assign compare_output_b = cmp_out_r[1];
   assign compare_output_c = cmp_out_r[2];
   assign status_flags = flag_r;
   assign irq_request = irq_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_COUNT_UP: assert property (
      (count_adv && !restart_hit) |=> (cnt_r == $past(cnt_r) + 1'b1))
      else $error("counter did not step up by one");
   AST_EXT_HOLD: assert property (
      (clock_select == CLK_SRC_EXT && !ext_rise) |=> $stable(cnt_r) && $stable(pre_cnt_r))
      else $error("counter moved without an external clock edge");
   AST_PRESCALE: assert property (
      count_adv |-> (src_tick && pre_cnt_r >= prescale_div))
      else $error("counter advanced before prescaler finished");
   AST_PRE_RESTART: assert property (
      count_adv |=> (pre_cnt_r == '0))
      else $error("prescaler not cleared after terminal count");
   AST_CMP_OUT: assert property (
      (cmp_hit[1] && compare_out_enable[1]) |=> (compare_output_b == $past(compare_active_level[1])))
      else $error("compare output b not active after match");
   AST_CAPTURE_A: assert property (
      cap_edge[0] |=> (capture_value_a == $past(cnt_r)))
      else $error("capture a did not take the counter value");
   AST_CAPTURE_B_EDGE: assert property (
      (capture_edge_b == EDGE_FALL && $fell(capture_input_b)) |-> cap_edge[1])
      else $error("falling edge on capture b missed");
   AST_IDLE_LEVEL: assert property (
      (!cmp_evt[2]) |=> (compare_output_c == !$past(compare_active_level[2])))
      else $error("compare output c not at idle level");
   AST_FORCE: assert property (
      force_compare[0] |=> status_flags[FLAG_CMP_A])
      else $error("forced compare did not set its flag");
   AST_IRQ: assert property (
      (|(flag_nxt & irq_enable)) |=> irq_request)
      else $error("enabled flag did not raise the interrupt");
   AST_FLAG_STICKY: assert property (
      (status_flags[FLAG_CAP_B] && !flag_clear[FLAG_CAP_B]) |=> status_flags[FLAG_CAP_B])
      else $error("capture b flag dropped without clear");
   AST_RESTART: assert property (
      (count_adv && restart_mode && cnt_r == compare_value_a) |=> (cnt_r == '0))
      else $error("restart mode did not return counter to zero");
   AST_ROLLOVER: assert property (
      (count_adv && !restart_hit && (&cnt_r)) |=> (cnt_r == '0) && status_flags[FLAG_ROLL])
      else $error("wrap did not set the rollover flag");

   // the checks below cover the hold, idle and clear paths that the match checks above leave open
   AST_HOLD_DISABLED: assert property (
      (!timer_enable) |=> $stable(cnt_r) && $stable(pre_cnt_r))
      else $error("counter or prescaler moved while disabled");

   AST_REF_TICK: assert property (
      (timer_enable && clock_select == CLK_SRC_REF) |-> src_tick)
      else $error("reference source gave no tick");

   AST_NO_ADV_HOLD: assert property (
      (!count_adv) |=> $stable(cnt_r))
      else $error("counter moved without a step");

   AST_EXT_TICK: assert property (
      (timer_enable && clock_select == CLK_SRC_EXT && ext_rise) |-> src_tick)
      else $error("external clock edge gave no tick");

   AST_EXT_PREV: assert property (
      1'b1 |=> (ext_prev_r == $past(external_counter_clock)))
      else $error("external clock sample not kept");

   AST_PRE_STEP: assert property (
      (src_tick && !pre_done) |=> (pre_cnt_r == $past(pre_cnt_r) + 1'b1))
      else $error("prescaler did not step on a tick");

   AST_PRE_IDLE: assert property (
      (!src_tick) |=> $stable(pre_cnt_r))
      else $error("prescaler moved without a tick");

   AST_CMP_FLAG_A: assert property (
      cmp_hit[0] |=> status_flags[FLAG_CMP_A])
      else $error("match a did not set its flag");

   AST_CMP_FLAG_C: assert property (
      cmp_hit[2] |=> status_flags[FLAG_CMP_C])
      else $error("match c did not set its flag");

   AST_CMP_OFF: assert property (
      (!compare_out_enable[1]) |=> (compare_output_b == !$past(compare_active_level[1])))
      else $error("disabled compare output b left idle level");

   AST_CAPTURE_B: assert property (
      cap_edge[1] |=> (capture_value_b == $past(cnt_r)))
      else $error("capture b did not take the counter value");

   AST_CAPTURE_HOLD: assert property (
      (!cap_edge[0]) |=> $stable(capture_value_a))
      else $error("capture a changed without a trigger");

   AST_CAP_OFF: assert property (
      (capture_edge_a == EDGE_OFF) |-> !cap_edge[0])
      else $error("capture a fired while switched off");

   AST_CAP_A_RISE: assert property (
      (capture_edge_a == EDGE_RISE && capture_input_a && !cap_prev_r[0]) |-> cap_edge[0])
      else $error("rising edge on capture a missed");

   AST_CMP_OUT_A: assert property (
      (cmp_evt[0] && compare_out_enable[0]) |=> (compare_output_a == $past(compare_active_level[0])))
      else $error("compare output a not active after event");

   AST_CMP_OUT_C: assert property (
      (cmp_evt[2] && compare_out_enable[2]) |=> (compare_output_c == $past(compare_active_level[2])))
      else $error("compare output c not active after event");

   AST_FORCE_B: assert property (
      force_compare[1] |=> status_flags[FLAG_CMP_B])
      else $error("forced compare b did not set its flag");

   AST_FORCE_PIN: assert property (
      (force_compare[2] && compare_out_enable[2]) |=> (compare_output_c == $past(compare_active_level[2])))
      else $error("forced compare c did not drive its pin");

   AST_CAP_FLAG_A: assert property (
      cap_edge[0] |=> status_flags[FLAG_CAP_A])
      else $error("capture a did not set its flag");

   AST_IRQ_LOW: assert property (
      (!(|(flag_nxt & irq_enable))) |=> !irq_request)
      else $error("interrupt raised with no enabled flag");

   AST_CLEAR: assert property (
      (flag_clear[FLAG_ROLL] && !wrap) |=> !status_flags[FLAG_ROLL])
      else $error("rollover flag not cleared");

   AST_FREE_RUN: assert property (
      (!restart_mode && count_adv && cnt_r == compare_value_a && !(&cnt_r)) |=> (cnt_r == $past(cnt_r) + 1'b1))
      else $error("free-run counter restarted on match a");

   AST_NO_ROLL_RESTART: assert property (
      (count_adv && restart_hit) |=> !$rose(status_flags[FLAG_ROLL]))
      else $error("restart raised the rollover flag");

   AST_WRAP_ONLY: assert property (
      $rose(status_flags[FLAG_ROLL]) |-> $past(wrap))
      else $error("rollover flag rose without a wrap");


   COV_RESTART: cover property (count_adv && restart_hit);
   COV_ROLLOVER: cover property (wrap);
   COV_CAPTURE_BOTH: cover property (cap_edge[0] ##[1:20] cap_edge[1]);
   COV_FORCE_CLEAR: cover property (force_compare[2] && flag_clear[FLAG_CMP_C]);

endmodule

/* File: verif/gpct_board_model.sv */
// carrier board model: external counter clock and capture pins
`timescale 1ns/100ps
module gpct_board_model (
   input wire logic ref_clk,
   input wire logic ext_run,
   input wire logic [1:0] cap_set,
   output logic external_counter_clock = 1'h0,
   output logic capture_input_a = 1'h0,
   output logic capture_input_b = 1'h0
);
   logic [1:0] ph_r = 2'h0;
   // clock runs at ref/6, well under the ref/2 sampling limit, and stands low when idle
   always @(posedge ref_clk) begin
      ph_r <= (ext_run && ph_r != 2'h2) ? ph_r + 2'h1 : 2'h0;
      if (!ext_run) external_counter_clock <= 1'h0;
      else if (ph_r == 2'h2) external_counter_clock <= ~external_counter_clock;
      capture_input_a <= cap_set[0];
      capture_input_b <= cap_set[1];
   end
endmodule

/* File: verif/gpct_timer_tb_top.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
module gpct_timer_tb_top import gpct_pkg::*; ();
   localparam int W = 8;
   logic ref_clk = 0, rst_n = 0, en = 0, csel = 0, rmode = 0, ext_run = 0;
   logic [1:0] cap = 0, ea = 0, eb = 0;
   logic [PRE_WIDTH-1:0] div = 0;
   logic [W-1:0] va = 0, vb = 0, vc = 0, cv, capa, capb, mx;
   logic [2:0] lvl = 0, oe = 0, frc = 0;
   logic [5:0] fclr = 0, ien = 0, fl;
   logic ext, cia, cib, coa, cob, coc, irq;
   int fail_count = 0, n_compared = 0, pb, pc;
   gpct_board_model i_board (.ref_clk(ref_clk), .ext_run(ext_run), .cap_set(cap),
      .external_counter_clock(ext), .capture_input_a(cia), .capture_input_b(cib));
   gpct_timer #(.CNT_W(W)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .timer_enable(en),
      .clock_select(csel), .external_counter_clock(ext), .prescale_div(div), .restart_mode(rmode),
      .compare_value_a(va), .compare_value_b(vb), .compare_value_c(vc), .compare_active_level(lvl),
      .compare_out_enable(oe), .force_compare(frc), .capture_input_a(cia), .capture_input_b(cib),
      .capture_edge_a(ea), .capture_edge_b(eb), .flag_clear(fclr), .irq_enable(ien),
      .counter_value(cv), .capture_value_a(capa), .capture_value_b(capb), .compare_output_a(coa),
      .compare_output_b(cob), .compare_output_c(coc), .status_flags(fl), .irq_request(irq));
   initial forever #20 ref_clk = ~ref_clk;
   // inputs move 2 ns after the edge so no race with the sampling edge
   task automatic step(int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic chk(logic [63:0] s, logic [63:0] e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, s, e);
      end
   endtask
   task automatic summarize();
      $display("compared=%0d mismatches=%0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rst(int n);
      rst_n = 0;
      step(n);
      rst_n = 1;
      step(1);
   endtask
   task automatic clr();
      fclr = 6'h3F;
      step(1);
      fclr = 6'h00;
   endtask
   task automatic win(int n);
      repeat (n) begin
         step(1);
         pb += (cob === 1'h1);
         pc += (coc === 1'h0);
      end
   endtask
   initial begin
      rst(12);
      csel = CLK_SRC_EXT;
      ext_run = 1;
      en = 1;
      step(60);
      chk(cv inside {[8'h09:8'h0A]}, 1'h1);
      ext_run = 0;
      csel = CLK_SRC_REF;
      en = 0;
      rst(2);
      div = 12'h002;
      en = 1;
      step(9);
      chk(cv, 8'h03);
      en = 0;
      step(5);
      chk(cv, 8'h03);
      for (int e = 0; e < 4; e++) begin
         ea = e[1:0];
         eb = e[1:0];
         clr();
         cap = 2'h3;
         step(3);
         chk(fl[1:0], {2{e[0]}});
         cap = 2'h0;
         step(3);
         chk(fl[1:0], {2{e != 0}});
      end
      chk(capa, 8'h03);
      chk(capb, 8'h03);
      div = 12'h000;
      va = 8'h64;
      vb = 8'h05;
      vc = 8'hC8;
      lvl = 3'h2;
      oe = 3'h6;
      ien = 6'h08;
      clr();
      pb = 0;
      pc = 0;
      en = 1;
      win(8);
      en = 0;
      frc = 3'h4;
      win(1);
      frc = 3'h0;
      win(4);
      chk(pb, 1);
      chk(pc, 1);
      chk(fl[4:2], 3'h6);
      chk(irq, 1'h1);
      chk(coa, 1'h1);
      // restart clears on channel a match, so the count never passes its value
      rst(2);
      rmode = 1;
      va = 8'h07;
      mx = 0;
      en = 1;
      repeat (30) begin
         step(1);
         if (cv > mx) mx = cv;
      end
      chk(mx, 8'h07);
      chk(fl[FLAG_CMP_A], 1'h1);
      chk(fl[FLAG_ROLL], 1'h0);
      rmode = 0;
      ien = 6'h20;
      clr();
      chk(irq, 1'h0);
      for (int i = 0; i < 300 && fl[FLAG_ROLL] !== 1'h1; i++) step(1);
      if (fl[FLAG_ROLL] !== 1'h1) fail_count++;
      chk(cv, 8'h00);
      chk(irq, 1'h1);
      summarize();
   end
endmodule
